/* hw/dpb_map.vh */
// constants for the dma port bridge: lengths, sizes, field positions, counts
// assumes a 32-bit byte address with longword-aligned dma requests
// Contract
// - dma writes to io space end with error
// - dma reads to io space end with error
// - lw/qw write as quad, hw/ow as octa
// - masked or unmasked form passes through
// - write latches buffer, invalidates read buffer
// - bus request only after all write data
// - prefetch enlarges read length per table
// - same hexaword, all valid: answer from buffer
// - clear valid bit as each longword goes
// - miss invalidates buffer and forwards read
// - same hexaword, prefetch outstanding: wait, answer
// - read hitting pending write hexaword waits
// - lock read flushes pending write first
// - reads served before pending writes
// - forwarded longword read raises bus priority
// - priority held for hold period after return
// - following write drops priority on completion
// - following longword read restarts hold period
// - following quadword read drops priority at issue
// - returned data buffered, unrequested kept prefetch
// - write, lock, bridge io invalidate prefetch
`ifndef DPB_MAP_VH
`define DPB_MAP_VH
// peripheral request lengths
`define DPB_LEN_LW 2'h0
`define DPB_LEN_QW 2'h1
`define DPB_LEN_HW 2'h2
`define DPB_LEN_OW 2'h3
// system bus transfer sizes
`define DPB_SZ_QUAD 2'h0
`define DPB_SZ_OCTA 2'h1
`define DPB_SZ_HEXA 2'h2
// address field positions
`define DPB_HEX_LSB 5
`define DPB_QW_LSB 3
`define DPB_LW_LSB 2
// timing counts and buffer shape
`define DPB_HOLD_CYC 16
`define DPB_FIFO_DEPTH 16
`define DPB_FIFO_W 36
`endif

/* hw/dpb_bridge.v */
// dma path of one peripheral port: write buffer with data fifo, read prefetch
// buffer, system bus sequencer and priority raise; instantiate once per port
// assumes requester and memory side are logic on sys_clk
`timescale 1ns/1ns
`include "dpb_map.vh"

module dpb_fifo #(
  parameter W = 36,
  parameter D = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // fill side
  input wire inValid,
  output reg inReady,
  input wire [W-1:0] inData,
  // drain side
  output reg outValid,
  input wire outReady,
  output wire [W-1:0] outData,
  output reg [AW:0] level
);
  localparam [AW:0] FULL = D;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW:0] levelNxt = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign outData = mem[rp_r];

  // pointers, level and registered full/empty flags
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      level <= levelNxt;
      inReady <= levelNxt != FULL;
      outValid <= levelNxt != {(AW+1){1'b0}};
    end
  end

  // storage
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= inData;
    end
  end
endmodule // dpb_fifo

module dpb_bridge #(
  parameter AW = 32,
  parameter PRIO_RAISE = 1,
  parameter [15:0] HOLD_CYC = `DPB_HOLD_CYC,
  parameter FIFO_DEPTH = `DPB_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // peripheral request
  input wire reqValid,
  output reg reqReady_r,
  input wire reqWrite,
  input wire reqLock,
  input wire reqIo,
  input wire [1:0] reqLen,
  input wire [AW-1:0] reqAddr,
  input wire reqMasked,
  // peripheral write data
  input wire wdValid,
  output wire wdReady,
  input wire [31:0] wdData,
  input wire [3:0] wdMask,
  // peripheral answers
  output reg rdValid_r,
  output reg [31:0] rdData_r,
  output reg rdDone_r,
  output reg wrDone_r,
  output reg portErrorN_r,
  // bridge-side controls
  input wire ioTxn,
  input wire prefetchEn,
  // system bus master
  output reg sbReq_r,
  input wire sbGnt,
  output reg sbCmdValid_r,
  output reg sbCmdWrite_r,
  output reg sbCmdLock_r,
  output reg [1:0] sbCmdSize_r,
  output reg [AW-1:0] sbAddr_r,
  output reg sbMasked_r,
  output reg sbWdValid_r,
  output reg [31:0] sbWdData_r,
  output reg [3:0] sbWdMask_r,
  input wire sbRdValid,
  input wire [63:0] sbRdData,
  // arbiter priority raise
  output reg dmaPriorityRaiseN_r
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CHK = 3'h1;
  localparam [2:0] ST_WAITW = 3'h2;
  localparam [2:0] ST_FWD = 3'h3;
  localparam [2:0] ST_SERVE = 3'h4;
  localparam [2:0] ST_WREQ = 3'h5;
  localparam [2:0] ST_WDATA = 3'h6;

  // longwords asked for, as a mask over the hexaword
  function [7:0] needMask;
    input [2:0] idx;
    input [1:0] len;
    reg [11:0] m;
    begin
      case (len)
        `DPB_LEN_LW: m = 12'h001;
        `DPB_LEN_QW: m = 12'h003;
        `DPB_LEN_HW: m = 12'h007;
        default: m = 12'h00f;
      endcase
      m = m << idx;
      needMask = m[7:0];
    end
  endfunction

  function [2:0] lwCount;
    input [1:0] len;
    begin
      lwCount = {1'b0, len} + 3'h1;
    end
  endfunction

  // system read size, enlarged when prefetching
  function [1:0] readSize;
    input [1:0] len;
    input pf;
    begin
      if (pf) begin
        case (len)
          `DPB_LEN_LW: readSize = `DPB_SZ_QUAD;
          `DPB_LEN_QW: readSize = `DPB_SZ_OCTA;
          `DPB_LEN_HW: readSize = `DPB_SZ_OCTA;
          default: readSize = `DPB_SZ_HEXA;
        endcase
      end else begin
        readSize = len[1] ? `DPB_SZ_OCTA : `DPB_SZ_QUAD;
      end
    end
  endfunction

  reg [2:0] state_r;
  reg [2:0] wRet_r;
  reg curWrite_r;
  reg curLock_r;
  reg curIo_r;
  reg [1:0] curLen_r;
  reg [AW-1:0] curAddr_r;
  reg curMasked_r;
  reg [AW-6:0] lastHex_r;
  reg lastHexV_r;
  reg [31:0] rbufMem [0:7];
  reg [7:0] valid_r;
  reg pfBusy_r;
  reg pfStale_r;
  reg [1:0] pfQuad_r;
  reg [1:0] pfMask_r;
  reg [2:0] pfLeft_r;
  reg [2:0] srvIdx_r;
  reg [2:0] srvLeft_r;
  reg wbufPend_r;
  reg wAck_r;
  reg [AW-1:0] wAddr_r;
  reg [1:0] wLen_r;
  reg wMasked_r;
  reg [1:0] wSlot_r;
  reg lwOut_r;
  reg holding_r;
  reg [15:0] holdCnt_r;
  reg [7:0] validNxt;

  wire [FIFO_AW:0] fifoLevel;
  wire [35:0] fifoOut;
  wire fifoOutValid;

  // read-side decode
  wire [AW-6:0] curHex = curAddr_r[AW-1:`DPB_HEX_LSB];
  wire sameHex = lastHexV_r && (curHex == lastHex_r);
  wire [7:0] need = needMask(curAddr_r[`DPB_HEX_LSB-1:`DPB_LW_LSB], curLen_r);
  wire hit = sameHex && ((valid_r & need) == need);
  wire wHexHit = wbufPend_r && (wAddr_r[AW-1:`DPB_HEX_LSB] == curHex);
  wire [1:0] rSize = readSize(curLen_r, prefetchEn);
  wire [2:0] rQuads = 3'h1 << rSize;
  wire [2:0] rQm1 = rQuads - 3'h1;
  wire isChk = state_r == ST_CHK;
  wire chkRead = isChk && !curIo_r && !curWrite_r;
  wire chkWrite = isChk && !curIo_r && curWrite_r && !wbufPend_r;
  wire chkLock = chkRead && curLock_r;
  wire chkWait = sameHex && pfBusy_r;
  wire chkMiss = chkRead && !curLock_r && !hit && !chkWait && !wHexHit;
  wire fwdGo = state_r == ST_FWD && sbReq_r && sbGnt;

  // write-side decode
  wire [2:0] wCnt = lwCount(wLen_r);
  wire wDataIn = wbufPend_r && (fifoLevel >= {{(FIFO_AW-2){1'b0}}, wCnt});
  wire [1:0] wLast = wLen_r[1] ? 2'h3 : 2'h1;
  wire [2:0] wOff = {1'b0, wAddr_r[3:2] & wLast};
  wire [2:0] wSlot3 = {1'b0, wSlot_r};
  wire wSlotUse = (wSlot3 >= wOff) && (wSlot3 < wOff + wCnt);
  wire fifoPop = state_r == ST_WDATA && wSlotUse && fifoOutValid;
  wire wrDoneNow = wbufPend_r && !wAck_r && wDataIn;

  // return and buffer bookkeeping
  wire inv = ioTxn || chkWrite || chkLock || chkMiss;
  wire rdAccept = sbRdValid && pfBusy_r;
  wire retDone = rdAccept && (pfLeft_r == 3'h1);
  wire retKeep = rdAccept && !pfStale_r && !inv;
  wire [7:0] retSet = retKeep ? (8'h03 << {pfQuad_r, 1'b0}) : 8'h00;
  wire srvGo = state_r == ST_SERVE && valid_r[srvIdx_r];
  wire [7:0] srvClr = srvGo ? (8'h01 << srvIdx_r) : 8'h00;

  dpb_fifo #(
    .W(`DPB_FIFO_W),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) uFifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(wdValid),
    .inReady(wdReady),
    .inData({wdMask, wdData}),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOut),
    .level(fifoLevel)
  );

  // valid bits: serve clears, invalidation wipes, a returning quad sets
  always @* begin
    validNxt = valid_r & ~srvClr;
    if (inv) begin
      validNxt = 8'h00;
    end
    validNxt = validNxt | retSet;
  end

  // read buffer storage, requested quadword lands first
  always @(posedge sys_clk) begin
    if (retKeep) begin
      rbufMem[{pfQuad_r, 1'b0}] <= sbRdData[31:0];
      rbufMem[{pfQuad_r, 1'b1}] <= sbRdData[63:32];
    end
  end

  // prefetch return tracking
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      valid_r <= 8'h00;
      pfBusy_r <= 1'b0;
      pfStale_r <= 1'b0;
      pfQuad_r <= 2'h0;
      pfMask_r <= 2'h0;
      pfLeft_r <= 3'h0;
    end else begin
      valid_r <= validNxt;
      if (inv && pfBusy_r) begin
        pfStale_r <= 1'b1; // late quads of an invalidated fetch are dropped
      end
      if (fwdGo) begin
        pfBusy_r <= 1'b1;
        pfStale_r <= 1'b0;
        pfQuad_r <= curAddr_r[`DPB_HEX_LSB-1:`DPB_QW_LSB];
        pfMask_r <= rQm1[1:0];
        pfLeft_r <= rQuads;
      end else if (rdAccept) begin
        pfQuad_r <= (pfQuad_r & ~pfMask_r) | ((pfQuad_r + 2'h1) & pfMask_r);
        pfLeft_r <= pfLeft_r - 3'h1;
        if (retDone) begin
          pfBusy_r <= 1'b0;
          pfStale_r <= 1'b0;
        end
      end
    end
  end

  // request sequencer and system bus master
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      wRet_r <= ST_IDLE;
      reqReady_r <= 1'b0;
      curWrite_r <= 1'b0;
      curLock_r <= 1'b0;
      curIo_r <= 1'b0;
      curLen_r <= 2'h0;
      curAddr_r <= {AW{1'b0}};
      curMasked_r <= 1'b0;
      lastHex_r <= {(AW-5){1'b0}};
      lastHexV_r <= 1'b0;
      srvIdx_r <= 3'h0;
      srvLeft_r <= 3'h0;
      wbufPend_r <= 1'b0;
      wAck_r <= 1'b0;
      wAddr_r <= {AW{1'b0}};
      wLen_r <= 2'h0;
      wMasked_r <= 1'b0;
      wSlot_r <= 2'h0;
      rdValid_r <= 1'b0;
      rdData_r <= 32'h00000000;
      rdDone_r <= 1'b0;
      wrDone_r <= 1'b0;
      portErrorN_r <= 1'b1;
      sbReq_r <= 1'b0;
      sbCmdValid_r <= 1'b0;
      sbCmdWrite_r <= 1'b0;
      sbCmdLock_r <= 1'b0;
      sbCmdSize_r <= 2'h0;
      sbAddr_r <= {AW{1'b0}};
      sbMasked_r <= 1'b0;
      sbWdValid_r <= 1'b0;
      sbWdData_r <= 32'h00000000;
      sbWdMask_r <= 4'h0;
    end else begin
      rdValid_r <= 1'b0;
      rdDone_r <= 1'b0;
      wrDone_r <= 1'b0;
      portErrorN_r <= 1'b1;
      sbCmdValid_r <= 1'b0;
      sbWdValid_r <= 1'b0;
      // peripheral side sees the write done once all data is held
      if (wrDoneNow) begin
        wrDone_r <= 1'b1;
        wAck_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (reqValid && reqReady_r) begin
            reqReady_r <= 1'b0;
            curWrite_r <= reqWrite;
            curLock_r <= reqLock;
            curIo_r <= reqIo;
            curLen_r <= reqLen;
            curAddr_r <= reqAddr;
            curMasked_r <= reqMasked;
            state_r <= ST_CHK;
          end else if (wDataIn) begin
            reqReady_r <= 1'b0;
            wRet_r <= ST_IDLE;
            state_r <= ST_WREQ;
          end else begin
            reqReady_r <= 1'b1;
          end
        end
        ST_CHK: begin
          srvIdx_r <= curAddr_r[`DPB_HEX_LSB-1:`DPB_LW_LSB];
          srvLeft_r <= lwCount(curLen_r);
          if (curIo_r) begin
            portErrorN_r <= 1'b0;
            reqReady_r <= 1'b1;
            state_r <= ST_IDLE;
          end else if (curWrite_r) begin
            if (wbufPend_r) begin
              state_r <= ST_WAITW;
            end else begin
              wbufPend_r <= 1'b1;
              wAck_r <= 1'b0;
              wAddr_r <= curAddr_r;
              wLen_r <= curLen_r;
              wMasked_r <= curMasked_r;
              reqReady_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end else if (curLock_r) begin
            state_r <= wbufPend_r ? ST_WAITW : ST_FWD;
          end else if (hit) begin
            lastHex_r <= curHex;
            state_r <= ST_SERVE;
          end else if (chkWait) begin
            state_r <= ST_CHK;
          end else if (wHexHit) begin
            state_r <= ST_WAITW;
          end else begin
            state_r <= ST_FWD;
          end
        end
        ST_WAITW: begin
          if (!wbufPend_r) begin
            state_r <= ST_CHK;
          end else if (wDataIn) begin
            wRet_r <= ST_WAITW;
            state_r <= ST_WREQ;
          end
        end
        ST_FWD: begin
          if (fwdGo) begin
            sbReq_r <= 1'b0;
            sbCmdValid_r <= 1'b1;
            sbCmdWrite_r <= 1'b0;
            sbCmdLock_r <= curLock_r;
            sbCmdSize_r <= rSize;
            sbAddr_r <= {curAddr_r[AW-1:`DPB_QW_LSB], 3'h0};
            sbMasked_r <= 1'b0;
            lastHex_r <= curHex;
            lastHexV_r <= 1'b1;
            state_r <= ST_SERVE;
          end else if (!pfBusy_r) begin
            sbReq_r <= 1'b1;
          end
        end
        ST_SERVE: begin
          if (srvGo) begin
            rdValid_r <= 1'b1;
            rdData_r <= rbufMem[srvIdx_r];
            srvIdx_r <= srvIdx_r + 3'h1;
            srvLeft_r <= srvLeft_r - 3'h1;
            if (srvLeft_r == 3'h1) begin
              rdDone_r <= 1'b1;
              reqReady_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_WREQ: begin
          if (sbReq_r && sbGnt) begin
            sbReq_r <= 1'b0;
            sbCmdValid_r <= 1'b1;
            sbCmdWrite_r <= 1'b1;
            sbCmdLock_r <= 1'b0;
            sbCmdSize_r <= wLen_r[1] ? `DPB_SZ_OCTA : `DPB_SZ_QUAD;
            sbAddr_r <= wLen_r[1] ? {wAddr_r[AW-1:4], 4'h0} : {wAddr_r[AW-1:3], 3'h0};
            sbMasked_r <= wMasked_r;
            wSlot_r <= 2'h0;
            state_r <= ST_WDATA;
          end else begin
            sbReq_r <= 1'b1;
          end
        end
        ST_WDATA: begin
          // slots outside the written longwords go out with a null mask
          sbWdValid_r <= 1'b1;
          sbWdData_r <= fifoPop ? fifoOut[31:0] : 32'h00000000;
          sbWdMask_r <= fifoPop ? fifoOut[35:32] : 4'h0;
          wSlot_r <= wSlot_r + 2'h1;
          if (wSlot_r == wLast) begin
            wbufPend_r <= 1'b0;
            reqReady_r <= wRet_r == ST_IDLE;
            state_r <= wRet_r;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // priority raise toward the system bus arbiter
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dmaPriorityRaiseN_r <= 1'b1;
      lwOut_r <= 1'b0;
      holding_r <= 1'b0;
      holdCnt_r <= 16'h0000;
    end else if (PRIO_RAISE != 0) begin
      if (fwdGo && curLen_r == `DPB_LEN_LW) begin
        dmaPriorityRaiseN_r <= 1'b0;
        lwOut_r <= 1'b1;
        holding_r <= 1'b0;
      end else if (fwdGo && curLen_r == `DPB_LEN_QW) begin
        dmaPriorityRaiseN_r <= 1'b1;
        holding_r <= 1'b0;
      end else if (wrDoneNow) begin
        dmaPriorityRaiseN_r <= 1'b1;
        holding_r <= 1'b0;
      end else if (retDone && lwOut_r) begin
        lwOut_r <= 1'b0;
        holding_r <= 1'b1;
        holdCnt_r <= HOLD_CYC;
      end else if (holding_r) begin
        if (holdCnt_r <= 16'h0001) begin
          dmaPriorityRaiseN_r <= 1'b1;
          holding_r <= 1'b0;
        end else begin
          holdCnt_r <= holdCnt_r - 16'h0001;
        end
      end
    end
  end
endmodule // dpb_bridge

/* dv/dpb_mem_model.sv */
// memory side model: grants requests, sinks writes, returns read quadwords
// assumes the bridge drives the system bus on sys_clk; stall slows answers
`timescale 1ns/1ns
module dpb_mem_model (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // bus from the bridge
  input wire sbReq_r,
  input wire sbCmdValid_r,
  input wire sbCmdWrite_r,
  input wire [1:0] sbCmdSize_r,
  input wire [31:0] sbAddr_r,
  // bench control
  input wire stall,
  // answers
  output reg sbGnt,
  output reg sbRdValid,
  output reg [63:0] sbRdData
);
  reg [2:0] left;
  reg [1:0] qIdx;
  reg [1:0] qMask;
  reg [31:0] blk;
  function [31:0] pat(input [31:0] a);
    pat = {a[31:2], 2'h0} ^ 32'h6b2d0000;
  endfunction
  // one grant per request; quadwords wrap in the aligned block, data toggles when idle
  always @(posedge sys_clk) begin
    sbGnt <= 1'b0;
    sbRdValid <= 1'b0;
    sbRdData <= ~sbRdData;
    if (sys_rst) begin
      left <= 3'h0;
      sbRdData <= 64'h0;
    end else if (!stall) begin
      sbGnt <= sbReq_r && !sbGnt;
      if (left != 3'h0) begin
        sbRdValid <= 1'b1;
        sbRdData <= {pat(blk | {qIdx & qMask, 3'h4}), pat(blk | {qIdx & qMask, 3'h0})};
        qIdx <= qIdx + 2'h1;
        left <= left - 3'h1;
      end
    end
    if (!sys_rst && sbCmdValid_r && !sbCmdWrite_r) begin
      left <= 3'h1 << sbCmdSize_r;
      qMask <= (2'h1 << sbCmdSize_r) - 2'h1;
      qIdx <= sbAddr_r[4:3];
      blk <= sbAddr_r & ~((32'h8 << sbCmdSize_r) - 32'h1);
    end
  end
endmodule // dpb_mem_model

/* dv/dpb_bridge_chk.sv */
// assertions on the pins of one dma port bridge
// assumes one sys_clk domain with synchronous active-high reset
`timescale 1ns/1ns
`include "dpb_map.vh"
module dpb_bridge_chk (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // request side
  input wire reqValid,
  input wire reqReady_r,
  input wire reqWrite,
  input wire reqIo,
  input wire [1:0] reqLen,
  input wire prefetchEn,
  // answers
  input wire rdValid_r,
  input wire rdDone_r,
  input wire wrDone_r,
  input wire portErrorN_r,
  // system bus
  input wire sbReq_r,
  input wire sbGnt,
  input wire sbCmdValid_r,
  input wire sbCmdWrite_r,
  input wire sbCmdLock_r,
  input wire [1:0] sbCmdSize_r,
  input wire sbWdValid_r,
  input wire dmaPriorityRaiseN_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg [1:0] rdLen_r;
  wire take = reqValid && reqReady_r;
  wire rdCmd = sbCmdValid_r && !sbCmdWrite_r;
  // length of the read being served
  always @(posedge sys_clk) begin
    if (take && !reqWrite) begin
      rdLen_r <= reqLen;
    end
  end
  sequence quadSlots;
    sbWdValid_r [*2] ##1 !sbWdValid_r;
  endsequence
  sequence octaSlots;
    sbWdValid_r [*4] ##1 !sbWdValid_r;
  endsequence
  chk_io_refused: assert property (take && reqIo |-> ##2 !portErrorN_r)
    else $error("io request not refused");
  chk_err_cause: assert property ($fell(portErrorN_r) |-> $past(take && reqIo, 2))
    else $error("error without io request");
  chk_write_size: assert property (sbCmdValid_r && sbCmdWrite_r |-> sbCmdSize_r != `DPB_SZ_HEXA)
    else $error("write size wrong");
  chk_quad_slots: assert property (sbCmdValid_r && sbCmdWrite_r && sbCmdSize_r == `DPB_SZ_QUAD |=> quadSlots)
    else $error("quad write slots wrong");
  chk_octa_slots: assert property (sbCmdValid_r && sbCmdWrite_r && sbCmdSize_r == `DPB_SZ_OCTA |=> octaSlots)
    else $error("octa write slots wrong");
  chk_cmd_granted: assert property (sbCmdValid_r |-> $past(sbReq_r && sbGnt))
    else $error("command without grant");
  chk_prefetch_size: assert property (rdCmd && prefetchEn && !sbCmdLock_r |-> sbCmdSize_r ==
    ((rdLen_r == `DPB_LEN_LW) ? `DPB_SZ_QUAD : (rdLen_r == `DPB_LEN_OW) ? `DPB_SZ_HEXA : `DPB_SZ_OCTA))
    else $error("prefetch size wrong");
  chk_prio_start: assert property ($fell(dmaPriorityRaiseN_r) |-> rdLen_r == `DPB_LEN_LW && (rdCmd || $past(rdCmd)))
    else $error("priority raised without longword read");
  chk_prio_write: assert property (wrDone_r |-> ##[0:1] dmaPriorityRaiseN_r)
    else $error("priority kept after write");
  chk_prio_quad: assert property (rdCmd && rdLen_r == `DPB_LEN_QW |-> ##[0:1] dmaPriorityRaiseN_r)
    else $error("priority kept at quadword read");
  chk_done_last: assert property (rdDone_r |-> rdValid_r)
    else $error("done without data");
endmodule // dpb_bridge_chk
bind dpb_bridge dpb_bridge_chk i_chk (.sys_clk, .sys_rst, .reqValid, .reqReady_r, .reqWrite, .reqIo, .reqLen,
  .prefetchEn, .rdValid_r, .rdDone_r, .wrDone_r, .portErrorN_r, .sbReq_r, .sbGnt, .sbCmdValid_r, .sbCmdWrite_r,
  .sbCmdLock_r, .sbCmdSize_r, .sbWdValid_r, .dmaPriorityRaiseN_r);

/* dv/dpb_bridge_test.sv */
// random and corner stimulus for one dma port bridge against a memory model
// assumes port two settings and a lengthened priority hold
`timescale 1ns/1ns
`include "dpb_map.vh"
module dpb_bridge_test;
  localparam HOLD = 24;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg reqValid = 1'b0, reqWrite = 1'b0, reqLock = 1'b0, reqIo = 1'b0, reqMasked = 1'b0;
  reg wdValid = 1'b0, ioTxn = 1'b0, prefetchEn = 1'b1, stall = 1'b0;
  reg [1:0] reqLen = 2'h0;
  reg [31:0] reqAddr = 32'h0, wdData = 32'h0, base;
  reg [3:0] wdMask = 4'h0;
  wire reqReady_r, wdReady, rdValid_r, rdDone_r, wrDone_r, portErrorN_r, sbReq_r, sbGnt, sbCmdValid_r;
  wire sbCmdWrite_r, sbCmdLock_r, sbMasked_r, sbWdValid_r, sbRdValid, dmaPriorityRaiseN_r;
  wire [1:0] sbCmdSize_r;
  wire [31:0] rdData_r, sbAddr_r, sbWdData_r;
  wire [3:0] sbWdMask_r;
  wire [63:0] sbRdData;
  integer numErrors = 0, samplesChecked = 0, seed = 32'h974b1082, numCmd = 0, i, n0;
  reg cmdW [0:255];
  reg [35:0] wq [$];
  reg [1:0] lastSize;
  reg lastMasked;
  always #5 sys_clk = ~sys_clk;
  dpb_bridge #(.HOLD_CYC(HOLD)) i_dut (.sys_clk, .sys_rst, .reqValid, .reqReady_r, .reqWrite, .reqLock, .reqIo,
    .reqLen, .reqAddr, .reqMasked, .wdValid, .wdReady, .wdData, .wdMask, .rdValid_r, .rdData_r, .rdDone_r,
    .wrDone_r, .portErrorN_r, .ioTxn, .prefetchEn, .sbReq_r, .sbGnt, .sbCmdValid_r, .sbCmdWrite_r, .sbCmdLock_r,
    .sbCmdSize_r, .sbAddr_r, .sbMasked_r, .sbWdValid_r, .sbWdData_r, .sbWdMask_r, .sbRdValid, .sbRdData,
    .dmaPriorityRaiseN_r);
  dpb_mem_model i_mem (.sys_clk, .sys_rst, .sbReq_r, .sbCmdValid_r, .sbCmdWrite_r, .sbCmdSize_r, .sbAddr_r,
    .stall, .sbGnt, .sbRdValid, .sbRdData);
  function [31:0] pat(input [31:0] a);
    pat = {a[31:2], 2'h0} ^ 32'h6b2d0000;
  endfunction
  function [1:0] pfSize(input [1:0] len);
    pfSize = (len == `DPB_LEN_LW) ? `DPB_SZ_QUAD : (len == `DPB_LEN_OW) ? `DPB_SZ_HEXA : `DPB_SZ_OCTA;
  endfunction
  task check(input ok, input [8*24-1:0] msg);
    begin
      samplesChecked = samplesChecked + 1;
      if (!ok) begin
        numErrors = numErrors + 1;
        $display("CHECK FAILED at %0t: %0s", $time, msg);
      end
    end
  endtask
  task giveVerdict;
    begin
      $display("errors %0d checks %0d", numErrors, samplesChecked);
      if (numErrors == 0 && samplesChecked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task push(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(negedge sys_clk);
        while (wdReady !== 1'b1) begin
          wdValid = 1'b0;
          @(negedge sys_clk);
        end
        wdValid = 1'b1;
        wdData = $random(seed);
        wdMask = reqMasked ? ($random(seed) | 4'h1) : 4'hf;
        wq.push_back({wdMask, wdData});
      end
      @(negedge sys_clk);
      wdValid = 1'b0;
    end
  endtask
  task req(input w, input lk, input io, input [1:0] len, input [31:0] a);
    begin
      @(negedge sys_clk);
      while (reqReady_r !== 1'b1) @(negedge sys_clk);
      {reqWrite, reqLock, reqIo, reqLen, reqAddr} = {w, lk, io, len, a};
      reqValid = 1'b1;
      @(negedge sys_clk);
      reqValid = 1'b0;
    end
  endtask
  task wr(input [1:0] len, input [31:0] a);
    begin
      push(len + 1);
      req(1'b1, 1'b0, 1'b0, len, a);
    end
  endtask
  task rd(input lk, input [1:0] len, input [31:0] a, input hit);
    integer n, c;
    begin
      c = numCmd;
      req(1'b0, lk, 1'b0, len, a);
      n = 0;
      while (n <= len) begin
        @(negedge sys_clk);
        if (rdValid_r === 1'b1) begin
          check(rdData_r === pat(a + 4 * n), "read data");
          n = n + 1;
        end
      end
      check((numCmd == c) === hit, "bus use on read");
    end
  endtask
  // log bus commands and compare every write slot that carries a mask
  always @(posedge sys_clk) begin
    if (sbCmdValid_r === 1'b1) begin
      cmdW[numCmd[7:0]] = sbCmdWrite_r;
      lastSize = sbCmdSize_r;
      lastMasked = sbMasked_r;
      numCmd = numCmd + 1;
    end
    if (sbWdValid_r === 1'b1 && sbWdMask_r !== 4'h0) begin
      check(wq.size() > 0 && wq[0] === {sbWdMask_r, sbWdData_r}, "write slot data");
      if (wq.size() > 0) void'(wq.pop_front());
    end
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    numErrors = numErrors + 1;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    giveVerdict;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    check({portErrorN_r, dmaPriorityRaiseN_r, sbReq_r} === 3'h6, "reset values");
    // io space requests end with an error pulse and no bus traffic
    for (i = 0; i < 2; i = i + 1) begin
      n0 = numCmd;
      req(i[0], 1'b0, 1'b1, 2'h0, $random(seed));
      @(negedge sys_clk);
      check(portErrorN_r === 1'b0, "io error pulse");
      check(numCmd === n0, "io reached bus");
    end
    // every write length and both mask forms
    for (i = 0; i < 4; i = i + 1) begin
      reqMasked = i[0];
      n0 = numCmd;
      wr(i[1:0], $random(seed) & ~((32'h4 << i) - 32'h1));
      while (numCmd == n0 || wq.size() > 0) @(negedge sys_clk);
      check(lastSize === (i < 2 ? `DPB_SZ_QUAD : `DPB_SZ_OCTA), "write size");
      check(lastMasked === i[0], "mask form");
    end
    // miss, prefetch hit, then the consumed word misses again
    for (i = 0; i < 4; i = i + 1) begin
      base = $random(seed) & 32'hffffffe0;
      rd(1'b0, i[1:0], base, 1'b0);
      check(lastSize === pfSize(i[1:0]), "prefetch size");
      rd(1'b0, (i == 2) ? 2'h0 : i[1:0], base + 4 * (i + 1), 1'b1);
      rd(1'b0, 2'h0, base + 4 * (i + 1), 1'b0);
    end
    // a write or a bridge io cycle drops prefetched words
    for (i = 0; i < 2; i = i + 1) begin
      base = $random(seed) & 32'hffffffe0;
      rd(1'b0, 2'h0, base, 1'b0);
      if (i == 0) begin
        wr(2'h0, base ^ 32'h100);
        while (wq.size() > 0) @(negedge sys_clk);
      end else begin
        @(negedge sys_clk);
        ioTxn = 1'b1;
        @(negedge sys_clk);
        ioTxn = 1'b0;
      end
      rd(1'b0, 2'h0, base + 4, 1'b0);
    end
    // buffered write against a read: same hexaword and lock wait, others pass
    for (i = 0; i < 3; i = i + 1) begin
      base = $random(seed) & 32'hffffffe0;
      stall = 1'b1;
      n0 = numCmd;
      wr(2'h0, base);
      fork
        rd(i == 1, 2'h0, base ^ (i == 0 ? 32'h4 : 32'h40), 1'b0);
        begin
          repeat (20) @(negedge sys_clk);
          stall = 1'b0;
        end
      join
      while (wq.size() > 0) @(negedge sys_clk);
      check(cmdW[n0[7:0]] === (i < 2), "write and read order");
    end
    // priority raise around longword reads and what ends it
    for (i = 0; i < 3; i = i + 1) begin
      prefetchEn = i != 1;
      rd(1'b0, 2'h0, $random(seed) & 32'hffffffe0, 1'b0);
      check(dmaPriorityRaiseN_r === 1'b0, "priority raised");
      if (i == 0) begin
        rd(1'b0, 2'h0, $random(seed) & 32'hffffffe0, 1'b0);
        repeat (HOLD / 2) @(negedge sys_clk);
        check(dmaPriorityRaiseN_r === 1'b0, "priority held");
        repeat (HOLD) @(negedge sys_clk);
      end else if (i == 1) begin
        rd(1'b0, 2'h1, $random(seed) & 32'hffffffe0, 1'b0);
      end else begin
        wr(2'h0, $random(seed) & 32'hfffffffc);
        repeat (3) @(negedge sys_clk);
      end
      check(dmaPriorityRaiseN_r === 1'b1, "priority dropped");
    end
    // fill the write fifo while the bus stalls, then drain five octaword writes
    stall = 1'b1;
    reqMasked = 1'b0;
    fork
      push(20);
      begin
        repeat (40) @(negedge sys_clk);
        check(wdReady === 1'b0, "fifo not refusing");
        for (i = 0; i < 5; i = i + 1) req(1'b1, 1'b0, 1'b0, 2'h3, base + 32 * i);
      end
      begin
        repeat (70) @(negedge sys_clk);
        stall = 1'b0;
      end
    join
    while (wq.size() > 0) @(negedge sys_clk);
    check(wdReady === 1'b1, "fifo not drained");
    giveVerdict;
  end
endmodule // dpb_bridge_test
